// file: common/move_shift_consts.svh
// Opcode patterns and field encodings for the move and shift decode.
// Assumes inclusion by bare name from design files.
`ifndef MOVE_SHIFT_CONSTS_SVH
`define MOVE_SHIFT_CONSTS_SVH

`define MEM_SHIFT_HI_PAT 7'h71
`define MEM_SHIFT_SZ_PAT 2'h3
`define MOVE_GRP_PAT 2'h0
`define FLAG_READ_PAT 10'h10B
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h3
`define SIZE_LONG 2'h2
`define SIZE_NONE 2'h0
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_IND 3'h2
`define MODE_POSTINC 3'h3
`define MODE_PREDEC 3'h4
`define MODE_DISP16 3'h5
`define MODE_INDEX 3'h6
`define MODE_EXT 3'h7
`define EXT_ABS_SHORT 3'h0
`define EXT_ABS_LONG 3'h1
`define EXT_PC_DISP 3'h2
`define EXT_PC_INDEX 3'h3
`define EXT_IMMEDIATE 3'h4
`define DIR_RIGHT 1'h0
`define DIR_LEFT 1'h1
`define FLAGS_RESET 5'h00

`endif

// file: common/move_shift_pkg.sv
// Types shared by the move and shift decode block.
// Assumes the constants header is compiled alongside.
package move_shift_pkg;

	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] regnum;
	} ea_t;

	typedef struct packed {
		logic x;
		logic n;
		logic z;
		logic v;
		logic c;
	} condition_code_byte_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SHIFT_RIGHT,
		OP_SHIFT_LEFT,
		OP_MOVE,
		OP_AREG_LOAD,
		OP_FLAG_READ
	} op_kind_t;

	typedef enum logic [3:0] {
		EA_DATA_REG,
		EA_ADDR_REG,
		EA_INDIRECT,
		EA_POSTINC,
		EA_PREDEC,
		EA_DISP16,
		EA_INDEXED,
		EA_ABS_SHORT,
		EA_ABS_LONG,
		EA_PC_DISP,
		EA_PC_INDEX,
		EA_IMMEDIATE,
		EA_INVALID
	} ea_class_t;

endpackage : move_shift_pkg

// file: hw/ea_mode_decode.sv
// Combinational effective address classifier.
// Assumes a six-bit mode and register field from the opcode.
`timescale 1ns/1ps
`include "move_shift_consts.svh"

module ea_mode_decode (
	input wire move_shift_pkg::ea_t i_ea,
	output move_shift_pkg::ea_class_t o_class,
	output logic o_data_alterable,
	output logic o_mem_alterable
);

	always_comb begin
		case (i_ea.mode)
			`MODE_DREG: o_class = move_shift_pkg::EA_DATA_REG;
			`MODE_AREG: o_class = move_shift_pkg::EA_ADDR_REG;
			`MODE_IND: o_class = move_shift_pkg::EA_INDIRECT;
			`MODE_POSTINC: o_class = move_shift_pkg::EA_POSTINC;
			`MODE_PREDEC: o_class = move_shift_pkg::EA_PREDEC;
			`MODE_DISP16: o_class = move_shift_pkg::EA_DISP16;
			`MODE_INDEX: o_class = move_shift_pkg::EA_INDEXED;
			default: begin
				case (i_ea.regnum)
					`EXT_ABS_SHORT: o_class = move_shift_pkg::EA_ABS_SHORT;
					`EXT_ABS_LONG: o_class = move_shift_pkg::EA_ABS_LONG;
					`EXT_PC_DISP: o_class = move_shift_pkg::EA_PC_DISP;
					`EXT_PC_INDEX: o_class = move_shift_pkg::EA_PC_INDEX;
					`EXT_IMMEDIATE: o_class = move_shift_pkg::EA_IMMEDIATE;
					default: o_class = move_shift_pkg::EA_INVALID;
				endcase
			end
		endcase
	end

	always_comb begin
		o_mem_alterable = 1'b0;
		case (o_class)
			move_shift_pkg::EA_INDIRECT,
			move_shift_pkg::EA_POSTINC,
			move_shift_pkg::EA_PREDEC,
			move_shift_pkg::EA_DISP16,
			move_shift_pkg::EA_INDEXED,
			move_shift_pkg::EA_ABS_SHORT,
			move_shift_pkg::EA_ABS_LONG: o_mem_alterable = 1'b1;
			default: o_mem_alterable = 1'b0;
		endcase
		o_data_alterable = o_mem_alterable |
			(o_class == move_shift_pkg::EA_DATA_REG);
	end

endmodule : ea_mode_decode

// file: hw/move_shift_instruction_decode.sv
// Decode and execute of memory shifts, moves, address loads and flag reads.
// Assumes the fetch side presents one opcode and its fetched source word
// with a one-cycle valid; the operand unit performs the actual accesses.
//
// Contract
// - Memory shift opcode pattern recognised.
// - Direction zero right, one left.
// - Memory shift needs memory alterable operand.
// - Memory shift: one bit, word size.
// - Shifted-out bit to carry, extend; zero fill.
// - General move field layout decoded.
// - Move size: 01 byte, 11 word, 10 long.
// - Move sets N Z, clears V C.
// - Move destination must be data alterable.
// - Byte move forbids address register source.
// - Effective address mode and register mapping.
// - Address register load opcode layout.
// - Word load sign-extends; long loads whole.
// - Address load: any source, flags kept.
// - Flag read opcode pattern recognised.
// - Flag read writes zero-extended flags word.
// - Flag read: word, data alterable destination.
`timescale 1ns/1ps
`include "move_shift_consts.svh"

module move_shift_instruction_decode #(
	parameter int DATA_W = 32
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_op_valid,
	input wire logic [15:0] i_opcode,
	input wire logic [DATA_W-1:0] i_src_data,
	output logic o_done,
	output logic o_illegal,
	output logic o_unclaimed,
	output move_shift_pkg::op_kind_t o_op,
	output logic [1:0] o_size,
	output move_shift_pkg::ea_t o_src_ea,
	output move_shift_pkg::ea_t o_dst_ea,
	output logic [DATA_W-1:0] o_result,
	output logic o_dst_write,
	output logic o_areg_write,
	output logic [2:0] o_areg_idx,
	output move_shift_pkg::condition_code_byte_t o_flags
);

	if (DATA_W != 32) begin : g_width_check
		$error("move_shift_instruction_decode serves only DATA_W of 32");
	end

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RESULT
	} state_t;

	state_t state_q;
	state_t state_d;
	move_shift_pkg::ea_t src_ea;
	move_shift_pkg::ea_t dst_ea;
	move_shift_pkg::ea_class_t src_class;
	logic src_data_alt;
	logic src_mem_alt;
	logic dst_data_alt;
	logic [1:0] size_field;
	logic is_shift;
	logic is_move_grp;
	logic is_areg_load;
	logic is_move;
	logic is_flag_read;
	logic bad;
	move_shift_pkg::op_kind_t op_d;
	logic [15:0] shifted;
	logic shift_out;
	logic [31:0] move_val;
	logic move_neg;
	logic move_zero;
	move_shift_pkg::condition_code_byte_t flags_d;
	logic [31:0] result_d;

	assign src_ea = move_shift_pkg::ea_t'(i_opcode[5:0]);
	assign dst_ea.mode = i_opcode[8:6];
	assign dst_ea.regnum = i_opcode[11:9];
	assign size_field = i_opcode[13:12];

	ea_mode_decode u_src_ea (
		.i_ea(src_ea),
		.o_class(src_class),
		.o_data_alterable(src_data_alt),
		.o_mem_alterable(src_mem_alt)
	);

	ea_mode_decode u_dst_ea (
		.i_ea(dst_ea),
		.o_class(),
		.o_data_alterable(dst_data_alt),
		.o_mem_alterable()
	);

	assign is_shift = (i_opcode[15:9] == `MEM_SHIFT_HI_PAT) &&
		(i_opcode[7:6] == `MEM_SHIFT_SZ_PAT);
	// Size zero is not a move.
	assign is_move_grp = (i_opcode[15:14] == `MOVE_GRP_PAT) &&
		(size_field != `SIZE_NONE);
	assign is_areg_load = is_move_grp && (dst_ea.mode == `MODE_AREG);
	assign is_move = is_move_grp && (dst_ea.mode != `MODE_AREG);
	assign is_flag_read = (i_opcode[15:6] == `FLAG_READ_PAT);

	always_comb begin
		bad = 1'b0;
		op_d = move_shift_pkg::OP_NONE;
		if (is_shift) begin
			op_d = (i_opcode[8] == `DIR_LEFT) ?
				move_shift_pkg::OP_SHIFT_LEFT : move_shift_pkg::OP_SHIFT_RIGHT;
			bad = !src_mem_alt;
		end else if (is_areg_load) begin
			op_d = move_shift_pkg::OP_AREG_LOAD;
			bad = (size_field == `SIZE_BYTE) ||
				(src_class == move_shift_pkg::EA_INVALID);
		end else if (is_move) begin
			op_d = move_shift_pkg::OP_MOVE;
			bad = !dst_data_alt ||
				(src_class == move_shift_pkg::EA_INVALID) ||
				((size_field == `SIZE_BYTE) &&
				(src_class == move_shift_pkg::EA_ADDR_REG));
		end else if (is_flag_read) begin
			op_d = move_shift_pkg::OP_FLAG_READ;
			bad = !src_data_alt;
		end
	end

	always_comb begin
		if (i_opcode[8] == `DIR_LEFT) begin
			shifted = {i_src_data[14:0], 1'b0};
			shift_out = i_src_data[15];
		end else begin
			shifted = {1'b0, i_src_data[15:1]};
			shift_out = i_src_data[0];
		end
	end

	always_comb begin
		case (size_field)
			`SIZE_BYTE: begin
				move_val = {24'h000000, i_src_data[7:0]};
				move_neg = i_src_data[7];
				move_zero = (i_src_data[7:0] == 8'h00);
			end
			`SIZE_WORD: begin
				move_val = {16'h0000, i_src_data[15:0]};
				move_neg = i_src_data[15];
				move_zero = (i_src_data[15:0] == 16'h0000);
			end
			default: begin
				move_val = i_src_data;
				move_neg = i_src_data[31];
				move_zero = (i_src_data == 32'h00000000);
			end
		endcase
	end

	always_comb begin
		flags_d = o_flags;
		result_d = 32'h00000000;
		case (op_d)
			move_shift_pkg::OP_SHIFT_LEFT,
			move_shift_pkg::OP_SHIFT_RIGHT: begin
				result_d = {16'h0000, shifted};
				flags_d.x = shift_out;
				flags_d.c = shift_out;
				flags_d.v = 1'b0;
				flags_d.n = shifted[15];
				flags_d.z = (shifted == 16'h0000);
			end
			move_shift_pkg::OP_MOVE: begin
				result_d = move_val;
				flags_d.n = move_neg;
				flags_d.z = move_zero;
				flags_d.v = 1'b0;
				flags_d.c = 1'b0;
			end
			move_shift_pkg::OP_AREG_LOAD: begin
				if (size_field == `SIZE_WORD) begin
					result_d = {{16{i_src_data[15]}}, i_src_data[15:0]};
				end else begin
					result_d = i_src_data;
				end
			end
			move_shift_pkg::OP_FLAG_READ: begin
				result_d = {27'h0000000, o_flags};
			end
			default: begin
				result_d = 32'h00000000;
			end
		endcase
	end

	always_comb begin
		case (state_q)
			ST_IDLE: state_d = i_op_valid ? ST_RESULT : ST_IDLE;
			ST_RESULT: state_d = i_op_valid ? ST_RESULT : ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Per-opcode handshake outputs, one cycle after valid.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_done <= 1'b0;
			o_illegal <= 1'b0;
			o_unclaimed <= 1'b0;
			o_dst_write <= 1'b0;
			o_areg_write <= 1'b0;
		end else begin
			o_done <= i_op_valid && (op_d != move_shift_pkg::OP_NONE) && !bad;
			o_illegal <= i_op_valid && (op_d != move_shift_pkg::OP_NONE) && bad;
			o_unclaimed <= i_op_valid && (op_d == move_shift_pkg::OP_NONE);
			o_dst_write <= i_op_valid && !bad &&
				(op_d != move_shift_pkg::OP_NONE) &&
				(op_d != move_shift_pkg::OP_AREG_LOAD);
			o_areg_write <= i_op_valid && !bad &&
				(op_d == move_shift_pkg::OP_AREG_LOAD);
		end
	end

	// Decoded operand description, held until the next opcode.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_op <= move_shift_pkg::OP_NONE;
			o_size <= `SIZE_NONE;
			o_src_ea <= '0;
			o_dst_ea <= '0;
			o_areg_idx <= 3'h0;
			o_result <= '0;
		end else if (i_op_valid) begin
			o_op <= op_d;
			o_areg_idx <= dst_ea.regnum;
			o_result <= bad ? 32'h00000000 : result_d;
			if (is_move_grp) begin
				o_size <= size_field;
				o_src_ea <= src_ea;
				o_dst_ea <= dst_ea;
			end else begin
				o_size <= `SIZE_WORD;
				o_src_ea <= src_ea;
				o_dst_ea <= src_ea;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_flags <= `FLAGS_RESET;
		end else if (i_op_valid && !bad) begin
			o_flags <= flags_d;
		end
	end

endmodule : move_shift_instruction_decode

// file: verif/move_shift_properties.sv
// Checker of the move and shift decode block ports.
// Assumes it is bound to the decode block.
`timescale 1ns/1ps
module move_shift_properties #(
	parameter int DATA_W = 32
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_op_valid,
	input wire logic [DATA_W-1:0] i_src_data,
	input wire logic o_done,
	input wire logic o_illegal,
	input wire logic o_unclaimed,
	input wire move_shift_pkg::op_kind_t o_op,
	input wire logic [1:0] o_size,
	input wire logic [DATA_W-1:0] o_result,
	input wire logic o_dst_write,
	input wire logic o_areg_write,
	input wire move_shift_pkg::condition_code_byte_t o_flags
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);
	one_answer_a: assert property (i_op_valid |=>
		$onehot({o_done, o_illegal, o_unclaimed})) else $error("bad answer");
	illegal_quiet_a: assert property (o_illegal |->
		!o_dst_write && !o_areg_write && o_result == 0 && $stable(o_flags))
		else $error("illegal op acted");
	shift_left_a: assert property (o_done &&
		o_op == move_shift_pkg::OP_SHIFT_LEFT |->
		o_result[15:0] == {$past(i_src_data[14:0]), 1'b0} &&
		o_flags.c == $past(i_src_data[15])) else $error("left shift wrong");
	shift_right_a: assert property (o_done &&
		o_op == move_shift_pkg::OP_SHIFT_RIGHT |->
		o_result[15:0] == {1'b0, $past(i_src_data[15:1])} &&
		o_flags.x == $past(i_src_data[0]) && !o_flags.v && o_size == 2'h3)
		else $error("right shift wrong");
	move_cc_a: assert property (o_done &&
		o_op == move_shift_pkg::OP_MOVE |->
		!o_flags.v && !o_flags.c && $stable(o_flags.x)) else $error("move cc");
	move_long_nz_a: assert property (o_done && o_size == 2'h2 &&
		o_op == move_shift_pkg::OP_MOVE |-> o_flags.n == o_result[31] &&
		o_flags.z == (o_result == 0)) else $error("move nz");
	areg_sext_a: assert property (o_areg_write && o_size == 2'h3 |->
		o_result == {{16{$past(i_src_data[15])}}, $past(i_src_data[15:0])})
		else $error("no sign ext");
	areg_flags_a: assert property (o_areg_write |->
		$stable(o_flags)) else $error("load changed flags");
	flag_read_a: assert property (o_done &&
		o_op == move_shift_pkg::OP_FLAG_READ |-> $stable(o_flags) &&
		o_result == {27'h0, o_flags}) else $error("flag read wrong");
	illegal_c: cover property (o_illegal);
	areg_c: cover property (o_areg_write);
	back2back_c: cover property (o_done ##1 o_done);
	flag_read_c: cover property (o_done &&
		o_op == move_shift_pkg::OP_FLAG_READ);
endmodule : move_shift_properties

// file: verif/operand_unit_model.sv
// Far-side operand unit: address registers and the last data write.
// Assumes the write strobes and result of the decode block.
`timescale 1ns/1ps
module operand_unit_model (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_dst_write,
	input wire logic i_areg_write,
	input wire logic [2:0] i_areg_idx,
	input wire logic [31:0] i_data,
	output logic [31:0] o_areg [8],
	output logic [31:0] o_last_wr
);
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_last_wr <= 32'h0;
		end else if (i_dst_write) begin
			o_last_wr <= i_data;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_areg_write) begin
			o_areg[i_areg_idx] <= i_data;
		end
	end
endmodule : operand_unit_model

// file: verif/tb.sv
// Self-checking bench of the move and shift decode block.
// Assumes the decode block, its checker and the operand unit model.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	typedef struct {
		logic [15:0] op;
		logic [31:0] src;
		logic [2:0] st;
		logic [1:0] wr;
		logic [2:0] k;
		logic [31:0] res;
	} row_t;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_op_valid = 1'b0;
	logic [15:0] i_opcode = 16'h0;
	logic [31:0] i_src_data = 32'h0;
	logic o_done, o_illegal, o_unclaimed, o_dst_write, o_areg_write;
	move_shift_pkg::op_kind_t o_op;
	logic [1:0] o_size;
	logic [2:0] o_areg_idx;
	logic [31:0] o_result, last_wr;
	logic [31:0] areg [8];
	move_shift_pkg::condition_code_byte_t o_flags;
	move_shift_pkg::ea_t src_ea, dst_ea;
	int fails = 0;
	int n_checks = 0;
	row_t rows [17] = '{
		'{16'hE3D0, 32'h8001, 4, 2, 2, 32'h2},
		'{16'hE2D0, 32'h8001, 4, 2, 1, 32'h4000},
		'{16'hE3F9, 32'h1, 4, 2, 2, 32'h2},
		'{16'hE3C0, 32'h1, 2, 0, 0, 32'h0},
		'{16'hE2FC, 32'h1, 2, 0, 0, 32'h0},
		'{16'h1200, 32'h80, 4, 2, 3, 32'h80},
		'{16'h2200, 32'h12345678, 4, 2, 3, 32'h12345678},
		'{16'h1208, 32'h1, 2, 0, 0, 32'h0},
		'{16'h29C0, 32'h1, 2, 0, 0, 32'h0},
		'{16'h23C0, 32'h5, 4, 2, 3, 32'h5},
		'{16'h203D, 32'h1, 2, 0, 0, 32'h0},
		'{16'h0200, 32'h1, 1, 0, 0, 32'h0},
		'{16'h2240, 32'h12345678, 4, 1, 4, 32'h12345678},
		'{16'h3048, 32'h7FFF, 4, 1, 4, 32'h7FFF},
		'{16'h1040, 32'h1, 2, 0, 0, 32'h0},
		'{16'h42C8, 32'h0, 2, 0, 0, 32'h0},
		'{16'h4E71, 32'h0, 1, 0, 0, 32'h0}
	};
	always #2.5 i_mclk = ~i_mclk;
	move_shift_instruction_decode #(.DATA_W(32)) u_dut (.i_mclk(i_mclk),
		.i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_opcode(i_opcode),
		.i_src_data(i_src_data), .o_done(o_done), .o_illegal(o_illegal),
		.o_unclaimed(o_unclaimed), .o_op(o_op), .o_size(o_size),
		.o_src_ea(src_ea), .o_dst_ea(dst_ea), .o_result(o_result),
		.o_dst_write(o_dst_write), .o_areg_write(o_areg_write),
		.o_areg_idx(o_areg_idx), .o_flags(o_flags));
	operand_unit_model u_model (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_dst_write(o_dst_write), .i_areg_write(o_areg_write),
		.i_areg_idx(o_areg_idx), .i_data(o_result), .o_areg(areg),
		.o_last_wr(last_wr));
	task automatic issue(input logic [15:0] op, input logic [31:0] src);
		@(negedge i_mclk);
		i_op_valid = 1'b1;
		i_opcode = op;
		i_src_data = src;
	endtask : issue
	task automatic idle();
		@(negedge i_mclk);
		i_op_valid = 1'b0;
	endtask : idle
	task automatic results();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	initial begin
		#20000;
		fails++;
		results();
	end
	initial begin
		logic [1:0] exp_size;
		repeat (3) @(negedge i_mclk);
		i_rst_b = 1'b1;
		foreach (rows[i]) begin
			issue(rows[i].op, rows[i].src);
			idle();
			exp_size = (rows[i].op[15:14] == 2'h0) ? rows[i].op[13:12] :
				2'h3;
			`CHK({o_done, o_illegal, o_unclaimed}, rows[i].st)
			`CHK({o_dst_write, o_areg_write}, rows[i].wr)
			if (rows[i].st != 3'h1) `CHK(o_result, rows[i].res)
			if (rows[i].st == 3'h4) `CHK(o_op, rows[i].k)
			if (rows[i].st == 3'h4) `CHK(src_ea, rows[i].op[5:0])
			if (rows[i].st == 3'h4) `CHK(o_size, exp_size)
		end
		issue(16'hE3D0, 32'h8001);
		issue(16'h2200, 32'h0);
		issue(16'h3040, 32'h8000);
		issue(16'h42C0, 32'h0);
		idle();
		`CHK(o_result, 32'h14)
		idle();
		`CHK(last_wr, 32'h14)
		`CHK(areg[0], 32'hFFFF8000)
		`CHK(areg[1], 32'h12345678)
		issue(16'h2B3A, 32'h80000000);
		idle();
		`CHK(o_flags.n, 1'b1)
		`CHK(src_ea, 6'h3A)
		`CHK(dst_ea, 6'h25)
		`CHK(o_size, 2'h2)
		i_rst_b = 1'b0;
		idle();
		`CHK({o_done, o_flags, o_result}, 38'h0)
		i_rst_b = 1'b1;
		idle();
		results();
	end
endmodule : tb
bind move_shift_instruction_decode move_shift_properties #(
	.DATA_W(DATA_W)) u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
	.i_op_valid(i_op_valid), .i_src_data(i_src_data), .o_done(o_done),
	.o_illegal(o_illegal), .o_unclaimed(o_unclaimed), .o_op(o_op),
	.o_size(o_size), .o_result(o_result), .o_dst_write(o_dst_write),
	.o_areg_write(o_areg_write), .o_flags(o_flags));
